//--- rtl/spi_pkg.sv
`default_nettype none

package spi_pkg;

  // ==========================================================
  // Bus geometry
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int BYTE_W = 8;

  // ==========================================================
  // Register indices and byte addresses
  localparam logic [7:0] IDX_CONTROL = 8'hd5;
  localparam logic [7:0] IDX_STATUS  = 8'haa;
  localparam logic [7:0] IDX_DATA    = 8'h86;
  localparam logic [7:0] IDX_AUX     = 8'ha8;

  localparam logic [ADDR_W-1:0] ADDR_CONTROL = {IDX_CONTROL, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_STATUS  = {IDX_STATUS, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_DATA    = {IDX_DATA, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_AUX     = {IDX_AUX, 2'h0};

  // ==========================================================
  // Field positions
  localparam int CTL_IRQ_EN = 7;
  localparam int CTL_ENABLE = 6;
  localparam int CTL_ORDER  = 5;
  localparam int CTL_MASTER = 4;
  localparam int CTL_CLOCK_POLARITY   = 3;
  localparam int CTL_CLOCK_PHASE   = 2;
  localparam int CTL_RATE_H = 1;
  localparam int CTL_RATE_L = 0;

  localparam int ST_DONE  = 7;
  localparam int ST_COLL  = 6;
  localparam int ST_LOAD  = 5;
  localparam int ST_SLAVE_OUTPUT_DISABLE = 1;
  localparam int ST_ENH   = 0;

  localparam int AUX_ES = 0;

  // ==========================================================
  // Reset values
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] DATA_RST    = 8'h00;

  // ==========================================================
  // Transfer timing
  localparam logic [3:0] BIT_LAST    = 4'h7;
  localparam logic [3:0] LOAD_WINDOW = 4'h4;
  localparam int HALF_W   = 6;
  localparam int DIV_CODE0 = 2;
  localparam int DIV_CODE1 = 8;
  localparam int DIV_CODE2 = 32;
  localparam int DIV_CODE3 = 64;

  // ==========================================================
  // Master sequencer states
  typedef enum logic [2:0] {
    M_IDLE = 3'h1,
    M_WAIT = 3'h2,
    M_RUN  = 3'h4
  } master_state_t;

endpackage : spi_pkg

`default_nettype wire

//--- rtl/spi_rate_gen.sv
`default_nettype none

// ============================================================
// Free running bit slot generator
module spi_rate_gen #(
  parameter int HALF_W = 6
) (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic [HALF_W-1:0] half_count,
  output logic                   half_tick,
  output logic                   slot_tick
);

  logic [HALF_W-1:0] cnt_q;
  logic              phase_q;

  assign half_tick = (cnt_q >= half_count - HALF_W'(1));
  assign slot_tick = half_tick & phase_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= '0;
    end else if (half_tick) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + HALF_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      phase_q <= 1'b0;
    end else if (half_tick) begin
      phase_q <= ~phase_q;
    end
  end

endmodule : spi_rate_gen

`default_nettype wire

//--- rtl/spi_shift_reg.sv
`default_nettype none

// ============================================================
// Byte shifter, either bit order
module spi_shift_reg #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         load,
  input  wire logic [W-1:0] load_data,
  input  wire logic         shift,
  input  wire logic         in_bit,
  input  wire logic         lsb_first,
  output logic [W-1:0]      q,
  output logic [W-1:0]      shifted,
  output logic              out_now
);

  assign shifted = lsb_first ? {in_bit, q[W-1:1]} : {q[W-2:0], in_bit};
  assign out_now = lsb_first ? q[0] : q[W-1];

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
    end else if (load) begin
      q <= load_data;
    end else if (shift) begin
      q <= shifted;
    end
  end

endmodule : spi_shift_reg

`default_nettype wire

//--- rtl/spi_master_slave_buffered.sv
// Behaviour
// [RL1] Clock pin output as master, input as slave
// [RL2] Master bit picks master and data directions
// [RL3] Master ignores slave select pin
// [RL4] Slave active only while select held low
// [RL5] Normal master data write starts transfer
// [RL6] Master start waits for next bit slot
// [RL7] After byte: stop, set done, store received
// [RL8] Interrupt needs both enables and done
// [RL9] Data address: write transmits, read receives
// [RL10] Normal busy write: collision, byte dropped
// [RL11] Buffered write fills buffer, flags full
// [RL12] Buffer move clears full; idle moves immediately
// [RL13] Load window high for first four bits
// [RL14] Software checks window and full before writing
// [RL15] Full at completion: reload, keep clocking
// [RL16] Enable bit connects pins, else disabled
// [RL17] Order bit one selects LSB first
// [RL18] Polarity bit sets idle clock level
// [RL19] Phase with polarity sets edge timing
// [RL20] Rate bits divide by 2/8/32/64
// [RL21] Software sets enable last, master first
// [RL22] Unloaded slave echoes last received byte
// [RL23] Status read then data access clears done
// [RL24] Output disable bit tristates slave data out
// [RL25] Phase zero samples leading, phase one trailing
// [RL26] Exactly eight clock cycles per byte
`default_nettype none

module spi_master_slave_buffered (
  input  wire logic                       clk,
  input  wire logic                       srst,
  input  wire logic [spi_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [3:0]                 avs_byteenable,
  input  wire logic [spi_pkg::DATA_W-1:0] avs_writedata,
  output logic [spi_pkg::DATA_W-1:0]      avs_readdata,
  output logic                            avs_waitrequest,
  input  wire logic                       sck_i,
  output logic                            sck_o,
  output logic                            sck_oe,
  input  wire logic                       mosi_i,
  output logic                            mosi_o,
  output logic                            mosi_oe,
  input  wire logic                       miso_i,
  output logic                            miso_o,
  output logic                            miso_oe,
  input  wire logic                       ss_n,
  output logic                            spi_irq
);

  // ==========================================================
  // Declarations
  logic [7:0]                  ctrl_q;
  logic                        enh_q;
  logic                        slave_output_disable_q;
  logic                        es_q;
  logic                        done_q;
  logic                        coll_q;
  logic                        armed_q;
  logic [7:0]                  txbuf_q;
  logic [7:0]                  rxbuf_q;
  logic [7:0]                  rdata_q;
  logic                        ack_q;
  logic                        sbusy_q;
  logic [3:0]                  bitcnt_q;
  logic                        sample_q;
  logic                        sck_q;
  logic                        sck_prev_q;
  logic                        out_q;
  spi_pkg::master_state_t      st_q;
  spi_pkg::master_state_t      st_d;

  logic                        en;
  logic                        master;
  logic                        slave_sel;
  logic                        clock_polarity;
  logic                        clock_phase;
  logic                        lsb;
  logic [spi_pkg::HALF_W-1:0]  half_count;
  logic                        half_tick;
  logic                        slot_tick;
  logic                        m_edge;
  logic                        lead;
  logic                        trail;
  logic                        last_trail;
  logic                        busy;
  logic                        active;
  logic                        load_win;
  logic                        req;
  logic                        take;
  logic                        wr_take;
  logic                        data_wr;
  logic                        data_rd;
  logic                        stat_rd;
  logic                        clr_seq;
  logic                        nrm_load;
  logic                        enh_move;
  logic                        enh_chain;
  logic                        sh_load;
  logic [7:0]                  sh_load_data;
  logic                        in_pin;
  logic [7:0]                  sh_q;
  logic [7:0]                  sh_shifted;
  logic                        sh_out;
  logic [7:0]                  status_val;

  function automatic logic first_bit(input logic [7:0] d, input logic lsb_first);
    first_bit = lsb_first ? d[0] : d[7];
  endfunction : first_bit

  // ==========================================================
  // Mode decode
  assign en        = ctrl_q[spi_pkg::CTL_ENABLE];                                 // RL16
  assign master    = en & ctrl_q[spi_pkg::CTL_MASTER];                            // RL2
  assign slave_sel = en & ~ctrl_q[spi_pkg::CTL_MASTER] & ~ss_n;                   // RL4
  assign clock_polarity      = ctrl_q[spi_pkg::CTL_CLOCK_POLARITY];
  assign clock_phase      = ctrl_q[spi_pkg::CTL_CLOCK_PHASE];
  assign lsb       = ctrl_q[spi_pkg::CTL_ORDER];                                  // RL17

  always_comb begin
    case ({ctrl_q[spi_pkg::CTL_RATE_H], ctrl_q[spi_pkg::CTL_RATE_L]})             // RL20
      2'h0:    half_count = spi_pkg::HALF_W'(spi_pkg::DIV_CODE0 / 2);
      2'h1:    half_count = spi_pkg::HALF_W'(spi_pkg::DIV_CODE1 / 2);
      2'h2:    half_count = spi_pkg::HALF_W'(spi_pkg::DIV_CODE2 / 2);
      default: half_count = spi_pkg::HALF_W'(spi_pkg::DIV_CODE3 / 2);
    endcase
  end

  spi_rate_gen #(
    .HALF_W (spi_pkg::HALF_W)
  ) u_rate (
    .clk        (clk),
    .srst       (srst),
    .half_count (half_count),
    .half_tick  (half_tick),
    .slot_tick  (slot_tick)
  );

  // ==========================================================
  // Edge detection, master and slave
  assign m_edge = ((st_q == spi_pkg::M_RUN) & half_tick)
                | ((st_q == spi_pkg::M_WAIT) & slot_tick);                       // RL6
  assign lead   = master ? (m_edge & (sck_q == clock_polarity))
                         : (slave_sel & (sck_prev_q == clock_polarity) & (sck_i != clock_polarity));   // RL1
  assign trail  = master ? (m_edge & (sck_q != clock_polarity))
                         : (slave_sel & (sck_prev_q != clock_polarity) & (sck_i == clock_polarity));
  assign last_trail = trail & (bitcnt_q == spi_pkg::BIT_LAST);                    // RL26
  assign busy     = master ? (st_q != spi_pkg::M_IDLE) : sbusy_q;
  assign active   = master ? (st_q == spi_pkg::M_RUN) : sbusy_q;
  assign load_win = active & (bitcnt_q < spi_pkg::LOAD_WINDOW);                   // RL13
  assign in_pin   = master ? miso_i : mosi_i;

  always_ff @(posedge clk) begin
    if (srst) begin
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_i;
    end
  end

  // ==========================================================
  // Register bus
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  assign take            = req & ack_q;
  assign wr_take         = avs_write & ack_q & avs_byteenable[0];
  assign data_wr         = wr_take & (avs_address == spi_pkg::ADDR_DATA);         // RL9
  assign data_rd         = avs_read & ack_q & (avs_address == spi_pkg::ADDR_DATA);
  assign stat_rd         = avs_read & ack_q & (avs_address == spi_pkg::ADDR_STATUS);
  assign clr_seq         = armed_q & (data_rd | data_wr);                         // RL23
  assign avs_readdata    = {{(spi_pkg::DATA_W - spi_pkg::BYTE_W){1'b0}}, rdata_q};

  always_comb begin
    status_val                    = 8'h00;
    status_val[spi_pkg::ST_DONE]  = done_q;
    status_val[spi_pkg::ST_COLL]  = coll_q;
    status_val[spi_pkg::ST_LOAD]  = load_win;
    status_val[spi_pkg::ST_SLAVE_OUTPUT_DISABLE] = slave_output_disable_q;
    status_val[spi_pkg::ST_ENH]   = enh_q;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= 8'h00;
    end else if (avs_read & ~ack_q) begin
      case (avs_address)
        spi_pkg::ADDR_CONTROL: rdata_q <= ctrl_q;
        spi_pkg::ADDR_STATUS:  rdata_q <= status_val;
        spi_pkg::ADDR_DATA:    rdata_q <= rxbuf_q;                                // RL9
        spi_pkg::ADDR_AUX:     rdata_q <= {7'h00, es_q};
        default:               rdata_q <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_q <= spi_pkg::CONTROL_RST;
    end else if (wr_take & (avs_address == spi_pkg::ADDR_CONTROL)) begin
      ctrl_q <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      enh_q   <= 1'b0;
      slave_output_disable_q <= 1'b0;
    end else if (wr_take & (avs_address == spi_pkg::ADDR_STATUS)) begin
      enh_q   <= avs_writedata[spi_pkg::ST_ENH];
      slave_output_disable_q <= avs_writedata[spi_pkg::ST_SLAVE_OUTPUT_DISABLE];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      es_q <= 1'b0;
    end else if (wr_take & (avs_address == spi_pkg::ADDR_AUX)) begin
      es_q <= avs_writedata[spi_pkg::AUX_ES];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      armed_q <= 1'b0;
    end else if (stat_rd) begin
      armed_q <= 1'b1;
    end else if (data_rd | data_wr) begin
      armed_q <= 1'b0;
    end
  end

  // ==========================================================
  // Transmit path and flags
  assign nrm_load  = data_wr & ~enh_q & ~busy;                                    // RL5
  assign enh_move  = enh_q & coll_q & ~busy;                                      // RL12
  assign enh_chain = enh_q & coll_q & last_trail;                                 // RL15
  assign sh_load   = nrm_load | enh_move | enh_chain;
  assign sh_load_data = nrm_load ? avs_writedata[7:0] : txbuf_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      txbuf_q <= spi_pkg::DATA_RST;
    end else if (data_wr & enh_q) begin
      txbuf_q <= avs_writedata[7:0];                                              // RL11
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      coll_q <= 1'b0;
    end else if (data_wr & (enh_q | busy)) begin
      coll_q <= 1'b1;                                                             // RL10 RL11
    end else if (enh_q ? (enh_move | enh_chain) : clr_seq) begin
      coll_q <= 1'b0;                                                             // RL12
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      done_q <= 1'b0;
    end else if (last_trail) begin
      done_q <= 1'b1;                                                             // RL7
    end else if (clr_seq) begin
      done_q <= 1'b0;                                                             // RL23
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rxbuf_q <= spi_pkg::DATA_RST;
    end else if (last_trail) begin
      rxbuf_q <= sh_shifted;                                                      // RL7
    end
  end

  assign spi_irq = done_q & ctrl_q[spi_pkg::CTL_IRQ_EN] & es_q;                   // RL8

  // ==========================================================
  // Shift register
  spi_shift_reg #(
    .W (spi_pkg::BYTE_W)
  ) u_shift (
    .clk       (clk),
    .srst      (srst),
    .load      (sh_load),
    .load_data (sh_load_data),
    .shift     (trail),
    .in_bit    (clock_phase ? in_pin : sample_q),                                        // RL22 RL25
    .lsb_first (lsb),
    .q         (sh_q),
    .shifted   (sh_shifted),
    .out_now   (sh_out)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      sample_q <= 1'b0;
    end else if (lead) begin
      sample_q <= in_pin;                                                         // RL25
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      out_q <= 1'b0;
    end else if (~active) begin
      out_q <= sh_load ? first_bit(sh_load_data, lsb) : sh_out;                   // RL25
    end else if (~clock_phase & trail) begin
      out_q <= sh_load ? first_bit(sh_load_data, lsb) : first_bit(sh_shifted, lsb); // RL19
    end else if (clock_phase & lead) begin
      out_q <= sh_out;                                                            // RL25
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      bitcnt_q <= 4'h0;
    end else if (~active) begin
      bitcnt_q <= 4'h0;
    end else if (trail) begin
      bitcnt_q <= last_trail ? 4'h0 : bitcnt_q + 4'h1;                            // RL26
    end
  end

  // ==========================================================
  // Slave sequencing
  always_ff @(posedge clk) begin
    if (srst) begin
      sbusy_q <= 1'b0;
    end else if (~slave_sel) begin
      sbusy_q <= 1'b0;                                                            // RL4
    end else if (last_trail) begin
      sbusy_q <= 1'b0;
    end else if (lead) begin
      sbusy_q <= 1'b1;
    end
  end

  // ==========================================================
  // Master sequencing
  always_comb begin
    st_d = st_q;
    case (st_q)
      spi_pkg::M_IDLE: begin
        if (master & sh_load) begin
          st_d = spi_pkg::M_WAIT;                                                 // RL5
        end
      end
      spi_pkg::M_WAIT: begin
        if (slot_tick) begin
          st_d = spi_pkg::M_RUN;                                                  // RL6
        end
      end
      spi_pkg::M_RUN: begin
        if (last_trail & ~enh_chain) begin
          st_d = spi_pkg::M_IDLE;                                                 // RL7 RL15
        end
      end
      default: st_d = spi_pkg::M_IDLE;
    endcase
    if (~master) begin
      st_d = spi_pkg::M_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= spi_pkg::M_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sck_q <= 1'b0;
    end else if (st_q == spi_pkg::M_IDLE) begin
      sck_q <= clock_polarity;                                                              // RL18
    end else if (m_edge) begin
      sck_q <= ~sck_q;
    end
  end

  // ==========================================================
  // Pins
  assign sck_o   = sck_q;
  assign sck_oe  = master;                                                        // RL1
  assign mosi_o  = out_q;
  assign mosi_oe = master;                                                        // RL2 RL3
  assign miso_o  = out_q;
  assign miso_oe = slave_sel & ~slave_output_disable_q;                                          // RL24 RL16

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_buf_full;
    coll_q && (st_q == spi_pkg::M_IDLE);
  endsequence

  sequence s_moved;
    !coll_q && (st_q != spi_pkg::M_IDLE);
  endsequence

  done_capture_a: assert property (last_trail |=> done_q && rxbuf_q == $past(sh_shifted)) // RL7
    else $error("done flag or received byte not captured");
  master_stop_a: assert property (master && last_trail && !enh_chain && master |=>  // RL7
    (st_q == spi_pkg::M_IDLE || !master))
    else $error("master did not stop after byte");
  chain_run_a: assert property (master && enh_chain && !data_wr |=>                // RL15
    st_q == spi_pkg::M_RUN && !coll_q)
    else $error("buffered byte not chained");
  collision_a: assert property (data_wr && !enh_q && busy |-> !sh_load ##1 coll_q) // RL10
    else $error("collision not flagged");
  idle_move_a: assert property (master && enh_q && data_wr && !busy && !coll_q     // RL12
    |=> s_buf_full ##1 s_moved)
    else $error("buffered byte not moved at idle");
  load_window_a: assert property (trail && bitcnt_q == 4'h3 && !last_trail |=> !load_win) // RL13
    else $error("load window too long");
  irq_gate_a: assert property (spi_irq |-> es_q && ctrl_q[spi_pkg::CTL_IRQ_EN] && done_q) // RL8
    else $error("interrupt without both enables");
  done_clear_a: assert property (clr_seq && !last_trail |=> !done_q)               // RL23
    else $error("done flag not cleared");
  miso_off_a: assert property ((master || slave_output_disable_q || !en) |-> !miso_oe)            // RL24
    else $error("slave output driven when it must float");
  disabled_pins_a: assert property (!en |-> !sck_oe && !mosi_oe)                  // RL16
    else $error("pins driven while disabled");
  sck_idle_a: assert property (master && st_q == spi_pkg::M_IDLE ##1              // RL18
    st_q == spi_pkg::M_IDLE |-> sck_o == $past(clock_polarity))
    else $error("idle clock level wrong");
  start_wait_a: assert property ($rose(st_q == spi_pkg::M_WAIT) |-> ##[1:130]      // RL6
    (st_q != spi_pkg::M_WAIT))
    else $error("master start never reached a bit slot");

endmodule : spi_master_slave_buffered

`default_nettype wire

//--- dv/spi_far_slave.sv
`default_nettype none

// ============================================================
// Far side slave model, shifts on the master's clock
module spi_far_slave (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       clock_polarity,
  input  wire logic       clock_phase,
  input  wire logic       lsb,
  input  wire logic       en,
  input  wire logic [7:0] tx,
  output logic            miso,
  output logic [7:0]      rx
);
  timeunit 1ns;
  timeprecision 1ns;
  int e = 0;
  int i;
  always_comb begin
    i    = clock_phase ? (e > 0 ? (e - 1) / 2 : 0) : e / 2;
    miso = lsb ? tx[i % 8] : tx[7 - i % 8];
  end
  always @(sck) begin
    if (!en) begin
      e = 0;
    end else begin
      if ((e % 2 == 0) == !clock_phase) begin
        rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
      end
      e = (e + 1) % 16;
    end
  end
endmodule : spi_far_slave

`default_nettype wire

//--- dv/spi_master_slave_buffered_test.sv
`default_nettype none

module spi_master_slave_buffered_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, srst = 1, rd = 0, wr = 0, ss_n = 1;
  logic [9:0]  addr = '0;
  logic [31:0] wd = '0, q, avs_readdata;
  logic [7:0]  c = 8'h00, b, tx_far = 8'h00, far_rx;
  logic        avs_waitrequest, sck_o, sck_oe, mosi_o, mosi_oe, miso_w, spi_irq;
  logic        sck_d = 0, sck_s = 0, mosi_s = 0, miso_s, miso_oe_s;
  logic [7:0]  r;
  int          miscompares = 0, checked = 0, hp = 0, cnt = 0;
  int          seed = 32'h903d_c045;
  int          divs[4] = '{2, 8, 32, 64};
  int          exp_q[$];

  spi_master_slave_buffered dut (.clk(clk), .srst(srst), .avs_address(addr),
    .avs_read(rd), .avs_write(wr), .avs_byteenable(4'hf), .avs_writedata(wd),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sck_i(sck_s), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_s), .mosi_o(mosi_o),
    .mosi_oe(mosi_oe), .miso_i(miso_w), .miso_o(miso_s), .miso_oe(miso_oe_s), .ss_n(ss_n),
    .spi_irq(spi_irq));
  spi_far_slave far (.sck(sck_o), .mosi(mosi_o), .clock_polarity(c[3]), .clock_phase(c[2]),
    .lsb(c[5]), .en(sck_oe), .tx(tx_far), .miso(miso_w), .rx(far_rx));

  // ==========================================================
  // Clock and half period meter
  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    sck_d <= sck_o;
    cnt   <= (sck_o != sck_d) ? 1 : cnt + 1;
    if (sck_o != sck_d) begin
      hp <= cnt;
    end
  end

  // ==========================================================
  // Tasks
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    rd   <= !w;
    wr   <= w;
    addr <= a;
    wd   <= 32'(d);
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 99);
    q  = avs_readdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 99) begin
      miscompares++;
      end_sim();
    end
  endtask : bus

  task automatic wait_done;
    int n;
    n = 0;
    do begin
      bus(1'b0, spi_pkg::ADDR_STATUS, 8'h00);
      n++;
    end while (q[spi_pkg::ST_DONE] !== 1'b1 && n < 2000);
    cmp(32'(q[spi_pkg::ST_DONE]), 1);
    if (n >= 2000) begin
      end_sim();
    end
  endtask : wait_done

  // External master, polarity 0, phase 0, MSB first
  task automatic ext_byte(input logic [7:0] d, output logic [7:0] rb);
    for (int j = 7; j >= 0; j--) begin
      mosi_s <= d[j];
      repeat (4) @(posedge clk);
      sck_s <= 1'b1;
      rb[j] = miso_s;
      repeat (4) @(posedge clk);
      sck_s <= 1'b0;
    end
    repeat (4) @(posedge clk);
  endtask : ext_byte

  task automatic end_sim;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  // ==========================================================
  // Watchdog
  initial begin
    #1_000_000;
    miscompares++;
    end_sim();
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    bus(1'b0, spi_pkg::ADDR_CONTROL, 8'h00);
    cmp(q, 32'(spi_pkg::CONTROL_RST));
    bus(1'b0, 10'h3fc, 8'h00);
    cmp(q, 0);
    bus(1'b1, spi_pkg::ADDR_AUX, 8'h01);
    for (int k = 0; k < 8; k++) begin
      c = (8'($random(seed)) & 8'hbf) | 8'h10;
      tx_far = 8'($random(seed));
      b = 8'($random(seed));
      ss_n <= k[0];
      exp_q.push_back(int'(tx_far));
      bus(1'b1, spi_pkg::ADDR_CONTROL, c);
      bus(1'b1, spi_pkg::ADDR_CONTROL, c | 8'h40);
      bus(1'b1, spi_pkg::ADDR_DATA, b);
      cmp({sck_oe, mosi_oe}, 2'b11);
      bus(1'b1, spi_pkg::ADDR_DATA, ~b);
      bus(1'b0, spi_pkg::ADDR_STATUS, 8'h00);
      cmp(32'(q[spi_pkg::ST_COLL]), 1);
      wait_done();
      cmp(32'(spi_irq), 32'(c[7]));
      cmp(hp, divs[c[1:0]] / 2);
      cmp(32'(sck_o), 32'(c[3]));
      bus(1'b0, spi_pkg::ADDR_DATA, 8'h00);
      cmp(q, exp_q.pop_front());
      cmp(32'(far_rx), 32'(b));
      bus(1'b0, spi_pkg::ADDR_STATUS, 8'h00);
      cmp(32'(q[7:6]), 0);
      cmp(32'(spi_irq), 0);
    end
    c = 8'h13;
    bus(1'b1, spi_pkg::ADDR_CONTROL, c);
    bus(1'b1, spi_pkg::ADDR_CONTROL, c | 8'h40);
    bus(1'b1, spi_pkg::ADDR_STATUS, 8'h01);
    bus(1'b1, spi_pkg::ADDR_DATA, 8'ha5);
    repeat (70) @(posedge clk);
    bus(1'b0, spi_pkg::ADDR_STATUS, 8'h00);
    cmp(32'(q[7:5]), 32'(3'b001));
    bus(1'b1, spi_pkg::ADDR_DATA, 8'h3c);
    bus(1'b1, spi_pkg::ADDR_DATA, 8'h5a);
    bus(1'b0, spi_pkg::ADDR_STATUS, 8'h00);
    cmp(32'(q[6:5]), 32'(2'b11));
    wait_done();
    cmp(32'(q[6]), 0);
    cmp(32'(far_rx), 32'(8'ha5));
    bus(1'b0, spi_pkg::ADDR_DATA, 8'h00);
    wait_done();
    cmp(32'(far_rx), 32'(8'h5a));
    bus(1'b0, spi_pkg::ADDR_DATA, 8'h00);
    ss_n <= 1'b0;
    bus(1'b1, spi_pkg::ADDR_CONTROL, 8'h00);
    bus(1'b1, spi_pkg::ADDR_STATUS, 8'h00);
    bus(1'b1, spi_pkg::ADDR_CONTROL, 8'h40);
    ext_byte(b, r);
    cmp(32'(miso_oe_s), 1);
    wait_done();
    bus(1'b0, spi_pkg::ADDR_DATA, 8'h00);
    cmp(q, 32'(b));
    ext_byte(8'(~b), r);
    cmp(32'(r), 32'(b));
    wait_done();
    bus(1'b0, spi_pkg::ADDR_DATA, 8'h00);
    ss_n <= 1'b1;
    ext_byte(b, r);
    cmp(32'(miso_oe_s), 0);
    bus(1'b0, spi_pkg::ADDR_STATUS, 8'h00);
    cmp(32'(q[spi_pkg::ST_DONE]), 0);
    end_sim();
  end
endmodule : spi_master_slave_buffered_test

`default_nettype wire
